/* File: verilog/dimp_defines.vh */
// Constants for the two-channel input module with parameter bank.
`ifndef DIMP_DEFINES_VH
`define DIMP_DEFINES_VH
`define DIMP_CLK_MHZ 125
`define DIMP_TICK_US 1
`define DIMP_TICK_CYC (`DIMP_CLK_MHZ * `DIMP_TICK_US)
`define DIMP_PARAM_BYTES 9
`define DIMP_DIAG_BYTES 20
`define DIMP_OFS_DIAG_IRQ 4'h0
`define DIMP_OFS_CHAN0_DLY 4'h1
`define DIMP_OFS_CHAN1_DLY 4'h2
`define DIMP_OFS_RISE_EN 4'h3
`define DIMP_OFS_FALL_EN 4'h4
`define DIMP_RST_DIAG_IRQ 8'h00
`define DIMP_RST_CHD 8'h02
`define DIMP_RST_RISE_EN 8'h00
`define DIMP_RST_FALL_EN 8'h00
`define DIMP_DIAG_ENABLE_CODE 8'h40
`define DIMP_DOFS_FAULT 5'h00
`define DIMP_DOFS_LOST 5'h03
`define DIMP_DOFS_US 5'h10
`define DIMP_LOST_BIT 6
`define DIMP_DIAG_INIT {96'h0, 64'h0002_0070_0000_1f00}
`define DIMP_DLY_C00 8'h00
`define DIMP_DLY_C02 8'h02
`define DIMP_DLY_C04 8'h04
`define DIMP_DLY_C07 8'h07
`define DIMP_DLY_C09 8'h09
`define DIMP_DLY_C0C 8'h0c
`define DIMP_DLY_US00 12'd1
`define DIMP_DLY_US02 12'd3
`define DIMP_DLY_US04 12'd10
`define DIMP_DLY_US07 12'd86
`define DIMP_DLY_US09 12'd342
`define DIMP_DLY_US0C 12'd2731
`endif

/* File: verilog/dimp_ram.v */
// Small byte memory holding the diagnostic record, registered read.
`timescale 1ns/10ps
module dimp_ram #(
  parameter WIDTH = 8,
  parameter DEPTH = 20,
  parameter AW = 5,
  parameter [WIDTH*DEPTH-1:0] INIT = {WIDTH*DEPTH{1'b0}}
) (
  // Clock and reset
  input wire mclk_i,
  input wire srst_i,
  // Write port
  input wire wr_i,
  input wire [AW-1:0] waddr_i,
  input wire [WIDTH-1:0] wdata_i,
  // Read port
  input wire [AW-1:0] raddr_i,
  output reg [WIDTH-1:0] rdata_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= INIT[i*WIDTH +: WIDTH];
    end
    else if (wr_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always @(posedge mclk_i)
  begin
    if (srst_i)
      rdata_o <= {WIDTH{1'b0}};
    else
      rdata_o <= mem[raddr_i];
  end
endmodule // dimp_ram

/* File: verilog/dimp_top.v */
// Two-channel filtered input module with parameter bank and interrupts.
// Behaviour
// R01: The input image byte carries channel 0 in bit 0, channel 1 in bit 1, zeros above.
// R02: The module takes no output-image bytes; there is no output area at all.
// R03: Each channel is filtered with a programmable delay on both edges before the image.
// R04: Each channel has its own one-byte delay setting that resets to 02h.
// R05: A rising-edge enable byte, reset 00h, raises a process interrupt on enabled rises.
// R06: A falling-edge enable byte, reset 00h, raises a process interrupt on enabled falls.
// R07: The diagnostic enable byte resets to 00h and suppresses diagnostic interrupts.
// R08: The host writes the diagnostic enable only while the system is stopped; the module accepts writes to it at any time.
// R09: A nine-byte parameter set and a twenty-byte diagnostic record are readable.
// R10: Each green channel indicator lights while its channel reads one.
// R11: The red fault indicator lights whenever the module status reports an error.
// R12: Diagnostic enable value 40h enables and 00h disables diagnostic interrupts.
// R13: Delay codes 00h,02h,04h,07h,09h,0Ch map to 1,3,10,86,342,2731 microseconds.
// R14: Bit 0 of each edge-enable byte governs channel 0, bit 1 channel 1, 1 enables.
// R15: Each process interrupt captures the edge source and a snapshot of both inputs.
// R16: Raw inputs pass two flip-flops and edges come from the filtered signal.
// R17: Filter timing counts stable one-microsecond ticks made from the system clock.
`timescale 1ns/10ps
`include "dimp_defines.vh"
module dimp_top #(
  parameter NCH = 2,
  parameter CW = 12
) (
  // Clock and reset
  input wire mclk_i,
  input wire srst_i,
  // Process inputs from the pins
  input wire [NCH-1:0] input_channel_i,
  // Module status
  input wire bus_ok_i,
  input wire module_error_i,
  // Parameter bank access
  input wire param_wr_i,
  input wire param_rd_i,
  input wire [3:0] param_addr_i,
  input wire [7:0] param_wdata_i,
  output reg [7:0] param_rdata_o,
  output reg param_rvalid_o,
  // Diagnostic record access
  input wire diag_rd_i,
  input wire [4:0] diag_addr_i,
  output reg [7:0] diag_rdata_o,
  output reg diag_rvalid_o,
  input wire diag_ack_i,
  output reg diag_irq_o,
  // Process image and interrupt
  output reg [7:0] input_image_o,
  output reg proc_irq_o,
  input wire proc_ack_i,
  output reg [7:0] edge_source_capture_o,
  output reg [7:0] input_state_snapshot_o,
  // Indicators
  output reg run_led_o,
  output reg module_fault_indicator_o,
  output reg [NCH-1:0] chan_led_o
);
  // Delay code to number of stable microsecond ticks; unknown codes fall back to 02h.
  function [CW-1:0] dly_ticks;
    input [7:0] code;
    begin
      case (code)
        `DIMP_DLY_C00: dly_ticks = `DIMP_DLY_US00; // R13
        `DIMP_DLY_C02: dly_ticks = `DIMP_DLY_US02;
        `DIMP_DLY_C04: dly_ticks = `DIMP_DLY_US04;
        `DIMP_DLY_C07: dly_ticks = `DIMP_DLY_US07;
        `DIMP_DLY_C09: dly_ticks = `DIMP_DLY_US09;
        `DIMP_DLY_C0C: dly_ticks = `DIMP_DLY_US0C;
        default: dly_ticks = `DIMP_DLY_US02;
      endcase
    end
  endfunction

  localparam [31:0] TICK_CYC = `DIMP_TICK_CYC;
  localparam [7:0] TICK_LAST = TICK_CYC[7:0] - 8'h01;

  reg [7:0] diag_irq_enable;
  reg [7:0] chan0_filter_delay;
  reg [7:0] chan1_filter_delay;
  reg [7:0] rising_edge_irq_enable;
  reg [7:0] falling_edge_irq_enable;
  reg [7:0] tick_cnt;
  reg tick;
  reg [31:0] us_ticker;
  reg [NCH-1:0] sync1;
  reg [NCH-1:0] sync2;
  wire [NCH-1:0] filt;
  reg [NCH-1:0] filt_q;
  reg [7:0] lost_status;
  reg diag_active;
  reg [31:0] us_latch;
  reg [2:0] us_wcnt;
  reg diag_rd_q;
  reg [4:0] diag_addr_q;
  wire [7:0] ram_rdata;
  wire [NCH-1:0] rise;
  wire [NCH-1:0] fall;
  wire [NCH-1:0] evt;
  wire lost;
  wire diag_irq_enable_on;

  // Parameter bank writes; no output area exists, so nothing else is written.
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      diag_irq_enable <= `DIMP_RST_DIAG_IRQ; // R07
      chan0_filter_delay <= `DIMP_RST_CHD; // R04
      chan1_filter_delay <= `DIMP_RST_CHD;
      rising_edge_irq_enable <= `DIMP_RST_RISE_EN; // R05
      falling_edge_irq_enable <= `DIMP_RST_FALL_EN; // R06
    end
    else if (param_wr_i)
    begin
      case (param_addr_i)
        `DIMP_OFS_DIAG_IRQ: diag_irq_enable <= param_wdata_i;
        `DIMP_OFS_CHAN0_DLY: chan0_filter_delay <= param_wdata_i;
        `DIMP_OFS_CHAN1_DLY: chan1_filter_delay <= param_wdata_i;
        `DIMP_OFS_RISE_EN: rising_edge_irq_enable <= param_wdata_i;
        `DIMP_OFS_FALL_EN: falling_edge_irq_enable <= param_wdata_i;
        default: ; // R02
      endcase
    end
  end

  // Parameter read; bytes 5 to 8 of the set are reserved and read zero.
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      param_rdata_o <= 8'h00;
      param_rvalid_o <= 1'b0;
    end
    else
    begin
      param_rvalid_o <= param_rd_i && (param_addr_i < `DIMP_PARAM_BYTES); // R09
      case (param_addr_i)
        `DIMP_OFS_DIAG_IRQ: param_rdata_o <= diag_irq_enable;
        `DIMP_OFS_CHAN0_DLY: param_rdata_o <= chan0_filter_delay;
        `DIMP_OFS_CHAN1_DLY: param_rdata_o <= chan1_filter_delay;
        `DIMP_OFS_RISE_EN: param_rdata_o <= rising_edge_irq_enable;
        `DIMP_OFS_FALL_EN: param_rdata_o <= falling_edge_irq_enable;
        default: param_rdata_o <= 8'h00;
      endcase
    end
  end

  // Microsecond tick and free-running ticker.
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
      us_ticker <= 32'h0;
    end
    else
    begin
      tick <= (tick_cnt == TICK_LAST); // R17
      tick_cnt <= (tick_cnt == TICK_LAST) ? 8'h00 : tick_cnt + 8'h01;
      if (tick)
        us_ticker <= us_ticker + 32'h1;
    end
  end

  // Two-stage synchronisers.
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      sync1 <= {NCH{1'b0}};
      sync2 <= {NCH{1'b0}};
    end
    else
    begin
      sync1 <= input_channel_i; // R16
      sync2 <= sync1;
    end
  end

  // Per-channel filter: a new level is taken after the selected number of stable ticks.
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : chan
      reg [CW-1:0] cnt;
      reg lvl;
      wire [CW-1:0] limit;
      assign limit = dly_ticks((g == 0) ? chan0_filter_delay : chan1_filter_delay); // R04
      assign filt[g] = lvl;
      always @(posedge mclk_i)
      begin
        if (srst_i)
        begin
          cnt <= {CW{1'b0}};
          lvl <= 1'b0;
        end
        else if (sync2[g] == lvl)
        begin
          cnt <= {CW{1'b0}};
        end
        else if (tick)
        begin
          if (cnt + {{(CW-1){1'b0}}, 1'b1} >= limit) // R03
          begin
            lvl <= sync2[g];
            cnt <= {CW{1'b0}};
          end
          else
          begin
            cnt <= cnt + {{(CW-1){1'b0}}, 1'b1}; // R17
          end
        end
      end
      assign rise[g] = filt[g] & ~filt_q[g] & rising_edge_irq_enable[g]; // R05 R14
      assign fall[g] = ~filt[g] & filt_q[g] & falling_edge_irq_enable[g]; // R06 R14
    end
  endgenerate

  assign evt = rise | fall; // R16
  assign lost = (|evt) && proc_irq_o && !proc_ack_i;
  assign diag_irq_enable_on = (diag_irq_enable == `DIMP_DIAG_ENABLE_CODE); // R12

  // Image, indicators and process interrupt; a new event beats a same-cycle ack.
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      filt_q <= {NCH{1'b0}};
      input_image_o <= 8'h00;
      chan_led_o <= {NCH{1'b0}};
      run_led_o <= 1'b0;
      module_fault_indicator_o <= 1'b0;
      proc_irq_o <= 1'b0;
      edge_source_capture_o <= 8'h00;
      input_state_snapshot_o <= 8'h00;
    end
    else
    begin
      filt_q <= filt;
      input_image_o <= {{(8-NCH){1'b0}}, filt}; // R01
      chan_led_o <= filt; // R10
      run_led_o <= bus_ok_i;
      module_fault_indicator_o <= module_error_i | diag_active; // R11
      if ((|evt) && !lost)
      begin
        proc_irq_o <= 1'b1;
        edge_source_capture_o <= {{(8-NCH){1'b0}}, evt}; // R15
        input_state_snapshot_o <= {{(8-NCH){1'b0}}, filt};
      end
      else if (proc_ack_i)
      begin
        proc_irq_o <= 1'b0;
      end
    end
  end

  // Diagnostic state: a lost process interrupt is incoming until the host acknowledges it.
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      lost_status <= 8'h00;
      diag_active <= 1'b0;
      diag_irq_o <= 1'b0;
      us_latch <= 32'h0;
      us_wcnt <= 3'd0;
    end
    else
    begin
      if (lost && !diag_active)
      begin
        diag_active <= 1'b1;
        lost_status[`DIMP_LOST_BIT] <= 1'b1;
        us_latch <= us_ticker;
        us_wcnt <= 3'd4;
      end
      else if (diag_ack_i && !lost)
      begin
        diag_active <= 1'b0;
        lost_status <= 8'h00;
      end
      if (us_wcnt != 3'd0 && !(lost && !diag_active))
        us_wcnt <= us_wcnt - 3'd1;
      diag_irq_o <= diag_active && diag_irq_enable_on; // R07 R12
    end
  end

  wire ram_wr = (us_wcnt != 3'd0);
  wire [1:0] us_idx = us_wcnt[1:0] - 2'd1;

  dimp_ram #(
    .WIDTH(8),
    .DEPTH(`DIMP_DIAG_BYTES),
    .AW(5),
    .INIT(`DIMP_DIAG_INIT)
  ) u_ram (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .wr_i(ram_wr),
    .waddr_i(`DIMP_DOFS_US + {3'd0, us_idx}),
    .wdata_i(us_latch[us_idx*8 +: 8]),
    .raddr_i(diag_addr_i),
    .rdata_o(ram_rdata)
  );

  // Diagnostic read, two cycles; error bytes come from live state.
  always @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      diag_rd_q <= 1'b0;
      diag_addr_q <= 5'h00;
      diag_rdata_o <= 8'h00;
      diag_rvalid_o <= 1'b0;
    end
    else
    begin
      diag_rd_q <= diag_rd_i && (diag_addr_i < `DIMP_DIAG_BYTES); // R09
      diag_addr_q <= diag_addr_i;
      diag_rvalid_o <= diag_rd_q;
      case (diag_addr_q)
        `DIMP_DOFS_FAULT: diag_rdata_o <= {7'h00, module_error_i | diag_active};
        `DIMP_DOFS_LOST: diag_rdata_o <= lost_status;
        default: diag_rdata_o <= ram_rdata;
      endcase
    end
  end
endmodule // dimp_top

/* File: test/dimp_asserts.sv */
// Port checks for the two-channel input module.
`timescale 1ns/10ps
module dimp_asserts #(
  parameter NCH = 2
) (
  // Clock and reset
  input wire mclk_i,
  input wire srst_i,
  // Watched ports
  input wire module_error_i,
  input wire param_rd_i,
  input wire [3:0] param_addr_i,
  input wire param_rvalid_o,
  input wire diag_rd_i,
  input wire [4:0] diag_addr_i,
  input wire diag_rvalid_o,
  input wire diag_irq_o,
  input wire [7:0] input_image_o,
  input wire proc_irq_o,
  input wire proc_ack_i,
  input wire [7:0] edge_source_capture_o,
  input wire module_fault_indicator_o,
  input wire [NCH-1:0] chan_led_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  chk_image_upper: assert property (input_image_o[7:2] == 6'h00)
    else $error("image upper bits set");
  chk_led_image: assert property (chan_led_o == input_image_o[NCH-1:0])
    else $error("channel led differs from image");
  chk_fault_led: assert property (!$past(srst_i) && $past(module_error_i) |-> module_fault_indicator_o)
    else $error("fault led dark on error");
  chk_param_valid: assert property (param_rd_i && param_addr_i < 4'h9 |=> param_rvalid_o)
    else $error("param read gave no valid");
  chk_param_refuse: assert property (param_rd_i && param_addr_i > 4'h8 |=> !param_rvalid_o)
    else $error("param read beyond set answered");
  chk_diag_valid: assert property (diag_rd_i && diag_addr_i < 5'h14 |-> ##2 diag_rvalid_o)
    else $error("diag read gave no valid");
  chk_irq_hold: assert property (proc_irq_o && !proc_ack_i |=> proc_irq_o)
    else $error("process irq dropped without ack");
  chk_diag_fault: assert property (diag_irq_o |-> module_fault_indicator_o)
    else $error("diag irq without fault led");
  chk_edge_src: assert property ($rose(proc_irq_o) |-> edge_source_capture_o[7:2] == 6'h00 && edge_source_capture_o[1:0] != 2'b00)
    else $error("bad edge source");
endmodule // dimp_asserts

bind dimp_top dimp_asserts #(.NCH(NCH)) i_dimp_asserts (
  .mclk_i(mclk_i), .srst_i(srst_i), .module_error_i(module_error_i),
  .param_rd_i(param_rd_i), .param_addr_i(param_addr_i), .param_rvalid_o(param_rvalid_o),
  .diag_rd_i(diag_rd_i), .diag_addr_i(diag_addr_i), .diag_rvalid_o(diag_rvalid_o),
  .diag_irq_o(diag_irq_o), .input_image_o(input_image_o), .proc_irq_o(proc_irq_o),
  .proc_ack_i(proc_ack_i), .edge_source_capture_o(edge_source_capture_o),
  .module_fault_indicator_o(module_fault_indicator_o), .chan_led_o(chan_led_o)
);

/* File: test/dimp_host.sv */
// Host model that acknowledges interrupts of the input module.
`timescale 1ns/10ps
module dimp_host (
  // Clock and control
  input wire mclk_i,
  input wire hold_i,
  // Interrupt lines
  input wire proc_irq_o,
  input wire diag_irq_o,
  output reg proc_ack_i,
  output reg diag_ack_i
);
  initial proc_ack_i = 1'b0;
  initial diag_ack_i = 1'b0;
  // A one-cycle ack follows each raised interrupt unless the bench holds the host off.
  always @(negedge mclk_i)
  begin
    proc_ack_i <= proc_irq_o && !hold_i && !proc_ack_i;
    diag_ack_i <= diag_irq_o && !hold_i && !diag_ack_i;
  end
endmodule // dimp_host

/* File: test/dimp_tb_top.sv */
// Self-checking bench for the two-channel input module.
`timescale 1ns/10ps
module dimp_tb_top;
  localparam [47:0] CODES = 48'h00_02_04_07_09_0c;
  localparam [71:0] TICKS = 72'h001_003_00a_056_156_aab;
  reg mclk_i = 0;
  reg srst_i = 1;
  reg hold = 0;
  reg bus_ok_i = 0;
  reg module_error_i = 0;
  reg param_wr_i = 0;
  reg param_rd_i = 0;
  reg diag_rd_i = 0;
  reg [1:0] input_channel_i = 0;
  reg [3:0] param_addr_i = 0;
  reg [7:0] param_wdata_i = 0;
  reg [4:0] diag_addr_i = 0;
  wire proc_ack_i, diag_ack_i, param_rvalid_o, diag_rvalid_o, diag_irq_o, proc_irq_o;
  wire run_led_o, module_fault_indicator_o;
  wire [7:0] param_rdata_o, diag_rdata_o, input_image_o, edge_source_capture_o;
  wire [7:0] input_state_snapshot_o;
  wire [1:0] chan_led_o;
  reg [7:0] rq[$];
  reg [15:0] eq[$];
  reg [7:0] last_img = 0;
  reg last_irq = 0;
  reg [1:0] re, fe;
  integer failures = 0;
  integer comparisons = 0;
  integer k;
  always #4 mclk_i = ~mclk_i;
  dimp_top i_dimp_top (.mclk_i(mclk_i), .srst_i(srst_i), .input_channel_i(input_channel_i),
    .bus_ok_i(bus_ok_i), .module_error_i(module_error_i), .param_wr_i(param_wr_i),
    .param_rd_i(param_rd_i), .param_addr_i(param_addr_i), .param_wdata_i(param_wdata_i),
    .param_rdata_o(param_rdata_o), .param_rvalid_o(param_rvalid_o), .diag_rd_i(diag_rd_i),
    .diag_addr_i(diag_addr_i), .diag_rdata_o(diag_rdata_o), .diag_rvalid_o(diag_rvalid_o),
    .diag_ack_i(diag_ack_i), .diag_irq_o(diag_irq_o), .input_image_o(input_image_o),
    .proc_irq_o(proc_irq_o), .proc_ack_i(proc_ack_i),
    .edge_source_capture_o(edge_source_capture_o),
    .input_state_snapshot_o(input_state_snapshot_o), .run_led_o(run_led_o),
    .module_fault_indicator_o(module_fault_indicator_o), .chan_led_o(chan_led_o));
  dimp_host i_dimp_host (.mclk_i(mclk_i), .hold_i(hold), .proc_irq_o(proc_irq_o),
    .diag_irq_o(diag_irq_o), .proc_ack_i(proc_ack_i), .diag_ack_i(diag_ack_i));
  task tally(input [47:0] name, input [15:0] exp, input [15:0] got);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("unexpected %0s exp %h got %h", name, exp, got);
    end
  end
  endtask
  task cmp_rd(input [7:0] exp, input [7:0] got);
    tally("read", {8'h00, exp}, {8'h00, got});
  endtask
  task cmp_ev(input [15:0] exp, input [15:0] got);
    tally("event", exp, got);
  endtask
  task report_and_stop;
  begin
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task pwr(input [3:0] a, input [7:0] d);
  begin
    param_addr_i = a;
    param_wdata_i = d;
    param_wr_i = 1;
    @(negedge mclk_i);
    param_wr_i = 0;
    @(negedge mclk_i);
  end
  endtask
  task prd(input [3:0] a, input [7:0] e);
  begin
    if (a < 9) rq.push_back(e);
    param_addr_i = a;
    param_rd_i = 1;
    @(negedge mclk_i);
    param_rd_i = 0;
    @(negedge mclk_i);
  end
  endtask
  task drd(input [4:0] a, input [7:0] e);
  begin
    if (a < 20) rq.push_back(e);
    diag_addr_i = a;
    diag_rd_i = 1;
    @(negedge mclk_i);
    diag_rd_i = 0;
    repeat (2) @(negedge mclk_i);
  end
  endtask
  // Moves the pins, notes the image and irq due, and checks the image holds for n-1 microseconds of its n microsecond delay.
  task pin(input [1:0] v, input integer n, input [15:0] irq);
    reg [7:0] old;
    integer j;
  begin
    old = input_image_o;
    input_channel_i = v;
    eq.push_back({14'h0, v});
    if (irq != 0) eq.push_back(irq);
    repeat ((n - 1) * 125) @(negedge mclk_i);
    cmp_ev({8'h00, old}, {8'h00, input_image_o});
    for (j = 0; j < (n + 2) * 125 && input_image_o !== {6'h0, v}; j = j + 1) @(negedge mclk_i);
    repeat (4) @(negedge mclk_i);
  end
  endtask
  always @(negedge mclk_i)
  begin
    if (param_rvalid_o === 1'b1 || diag_rvalid_o === 1'b1)
      cmp_rd(rq.size() ? rq.pop_front() : 8'hxx, param_rvalid_o ? param_rdata_o : diag_rdata_o);
    if (input_image_o !== last_img)
      cmp_ev(eq.size() ? eq.pop_front() : 16'hxxxx, {8'h00, input_image_o});
    if (proc_irq_o === 1'b1 && last_irq !== 1'b1)
      cmp_ev(eq.size() ? eq.pop_front() : 16'hxxxx, {edge_source_capture_o, input_state_snapshot_o});
    last_img <= input_image_o;
    last_irq <= proc_irq_o;
  end
  initial
  begin
    repeat (90000) @(posedge mclk_i);
    failures = failures + 1;
    report_and_stop;
  end
  initial
  begin
    void'($urandom(87));
    re = 2'($urandom);
    fe = 2'($urandom);
    repeat (8) @(negedge mclk_i);
    srst_i = 0;
    bus_ok_i = 1;
    prd(0, 8'h00);
    cmp_ev(16'h0001, {15'h0, run_led_o});
    prd(1, 8'h02);
    prd(2, 8'h02);
    prd(3, 8'h00);
    prd(4, 8'h00);
    pwr(5, 8'ha5);
    prd(5, 8'h00);
    prd(9, 8'h00);
    drd(1, 8'h1f);
    drd(4, 8'h70);
    drd(6, 8'h02);
    drd(20, 8'h00);
    for (k = 0; k < 6; k = k + 1)
    begin
      pwr(2, CODES[47-8*k -: 8]);
      prd(2, CODES[47-8*k -: 8]);
    end
    pwr(2, 8'h02);
    pwr(3, {6'h0, re});
    pwr(4, {6'h0, fe});
    prd(3, {6'h0, re});
    prd(4, {6'h0, fe});
    for (k = 0; k < 4; k = k + 1)
    begin
      pwr(1, CODES[47-8*k -: 8]);
      pin(2'b01, TICKS[71-12*k -: 12], re[0] ? 16'h0101 : 16'h0);
      pin(2'b00, TICKS[71-12*k -: 12], fe[0] ? 16'h0100 : 16'h0);
    end
    input_channel_i = 2'b10;
    repeat (100) @(negedge mclk_i);
    input_channel_i = 2'b00;
    repeat (600) @(negedge mclk_i);
    pin(2'b10, 3, re[1] ? 16'h0202 : 16'h0);
    pin(2'b00, 3, fe[1] ? 16'h0200 : 16'h0);
    pwr(0, 8'h40);
    prd(0, 8'h40);
    pwr(1, 8'h02);
    pwr(3, 8'h03);
    pwr(4, 8'h03);
    hold = 1;
    pin(2'b01, 3, 16'h0101);
    pin(2'b00, 3, 16'h0);
    cmp_ev(16'h0001, {15'h0, diag_irq_o});
    drd(3, 8'h40);
    drd(0, 8'h01);
    pwr(0, 8'h00);
    repeat (3) @(negedge mclk_i);
    cmp_ev(16'h0000, {15'h0, diag_irq_o});
    hold = 0;
    module_error_i = 1;
    repeat (4) @(negedge mclk_i);
    module_error_i = 0;
    repeat (4) @(negedge mclk_i);
    cmp_ev(16'h0000, 16'(eq.size() + rq.size()));
    report_and_stop;
  end
endmodule // dimp_tb_top
